/* File: core/sri_pkg.sv */
// Behaviour
// - Receive-full interrupt only while receive enable set
// - Route select reads zero, ignores writes
// - Role bit one is master; reset master
// - Polarity sets idle clock level; ends match
// - Phase sets timing; phase zero toggles select
// - Wired-OR bit makes clock/data pins open-drain
// - Enable bit; clearing causes partial reset
// - Transmit-empty interrupt only while transmit enable set
// - Receive-full set when byte reaches receive register
// - Status read then data read clears receive-full
// - Error interrupts only while error enable set
// - Overflow keeps old byte, drops new one
// - Status read then data read clears overflow
// - Mode fault on bad select level
// - Status read then control write clears mode fault
// - Transmit-empty set on handoff, cleared by write
// - Software writes data only while transmit empty
// - Mode fault enable gates setting, not clearing
// - Select pin use depends on role, enable
// - Master rate is base clock over twice divisor
// - Data address splits transmit and receive registers
// - No read-modify-write on data register
// - Disabled module aborts, clears, frees pins
package sri_pkg;
	// ==========================================
	// Device register map
	localparam logic [7:0] SRI_CTRL_OFS = 8'h1b;
	localparam logic [7:0] SRI_STAT_OFS = 8'h1c;
	localparam logic [7:0] SRI_DATA_OFS = 8'h1d;
	localparam logic [7:0] SRI_CTRL_RST = 8'h28;
	localparam logic [7:0] SRI_CTRL_WMASK = 8'hbf;
	localparam logic [3:0] SRI_STAT_CFG_RST = 4'h0;
	localparam logic [7:0] SRI_ZERO8 = 8'h00;
	localparam int CB_RIE = 7;
	localparam int CB_MSTR = 5;
	localparam int CB_CLOCK_POLARITY = 4;
	localparam int CB_CLOCK_PHASE = 3;
	localparam int CB_WOM = 2;
	localparam int CB_EN = 1;
	localparam int CB_TIE = 0;
	localparam int SB_ERROR_IRQ_ENABLE = 6;
	localparam int SB_MFEN = 2;
	localparam int SB_RATE_LO = 0;
	// ==========================================
	// Serial engine
	localparam int SRI_DIV_W = 8;
	localparam logic [4:0] SRI_LAST_EDGE = 5'h0f;
	localparam logic [SRI_DIV_W-1:0] SRI_BD [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
	// ==========================================
	// Controller registers and AXI answers
	localparam int SRI_AXI_AW = 8;
	localparam logic [SRI_AXI_AW-1:0] CTL_CMD_OFS = 8'h00;
	localparam logic [SRI_AXI_AW-1:0] CTL_STAT_OFS = 8'h04;
	localparam int CMD_READ_BIT = 16;
	localparam int ST_TE_BIT = 3;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CS_IDLE = 2'b00,
		CS_PULSE = 2'b01,
		CS_TAKE = 2'b10
	} sri_ctl_state_t;
endpackage

/* File: core/sri_bus_if.sv */
`timescale 1ns/1ps
interface sri_bus_if;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic irq;
	modport dev (input addr, input wr, input rd, input wdata, output rdata, output irq);
	modport ctl (output addr, output wr, output rd, output wdata, input rdata, input irq);
endinterface

/* File: core/sri_rate_div.sv */
`timescale 1ns/1ps
module sri_rate_div #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_run,
	input wire logic [W-1:0] i_div,
	// Half-period tick
	output logic o_tick
);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end
		else if (!i_run)
		begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end
		else if (cnt_reg == i_div - W'(1))
		begin
			cnt_reg <= '0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + W'(1);
			o_tick <= 1'b0;
		end
	end
endmodule

/* File: core/sri_device.sv */
`timescale 1ns/1ps
module sri_device
	import sri_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Register port
	sri_bus_if.dev bus,
	// Serial clock pin
	input wire logic i_sclk,
	output logic o_sclk,
	output logic o_sclk_oe_n,
	// Master-out data pin
	input wire logic i_mosi,
	output logic o_mosi,
	output logic o_mosi_oe_n,
	// Master-in data pin
	input wire logic i_miso,
	output logic o_miso,
	output logic o_miso_oe_n,
	// Select pin and pin ownership
	input wire logic i_ss_n,
	output logic o_ss_gpio,
	output logic o_pins_gpio
);
	logic [7:0] ctrl_reg;
	logic error_irq_enable_reg, mfen_reg;
	logic [1:0] rate_reg;
	logic rf_reg, ovr_reg, mode_fault_flag_reg, te_reg;
	logic [7:0] txd_reg, rxd_reg, shreg_reg;
	logic [2:0] arm_reg;
	logic xfer_reg, held_reg, cap_reg, out_bit_reg, sclk_reg, sclk_d_reg;
	logic [4:0] edge_reg;
	logic tick;

	// ==========================================
	// Decode
	logic en, mstr, clock_phase, wom;
	logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
	assign en = ctrl_reg[CB_EN];
	assign mstr = ctrl_reg[CB_MSTR];
	assign clock_phase = ctrl_reg[CB_CLOCK_PHASE];
	assign wom = ctrl_reg[CB_WOM];
	assign wr_ctrl = bus.wr && (bus.addr == SRI_CTRL_OFS);
	assign wr_stat = bus.wr && (bus.addr == SRI_STAT_OFS);
	assign wr_data = bus.wr && (bus.addr == SRI_DATA_OFS);
	assign rd_stat = bus.rd && (bus.addr == SRI_STAT_OFS);
	assign rd_data = bus.rd && (bus.addr == SRI_DATA_OFS);

	// ==========================================
	// Serial engine events
	logic sel, load, edge_ev, samp, last, done, sdi, rx_clr, full, mf_ev, ss_abort;
	logic [7:0] rx_word;
	assign sel = en && !mstr && !i_ss_n;
	assign load = en && !te_reg && !xfer_reg && !held_reg;
	assign edge_ev = mstr ? (xfer_reg && tick) : (sel && (i_sclk != sclk_d_reg));
	assign samp = !edge_reg[0] != clock_phase;
	assign last = edge_reg == SRI_LAST_EDGE;
	assign done = en && edge_ev && last;
	assign sdi = mstr ? i_miso : i_mosi;
	assign rx_word = {shreg_reg[6:0], clock_phase ? sdi : cap_reg};
	assign rx_clr = rd_data && arm_reg[0];
	assign full = rf_reg && !rx_clr;
	assign ss_abort = en && !mstr && xfer_reg && i_ss_n;
	assign mf_ev = mfen_reg && ((ss_abort) || (en && mstr && !i_ss_n));

	sri_rate_div #(
		.W(SRI_DIV_W)
	) u_div (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_run(en && mstr && xfer_reg),
		.i_div(SRI_BD[rate_reg]),
		.o_tick(tick)
	);

	// ==========================================
	// Control register
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			ctrl_reg <= SRI_CTRL_RST;
		else if (wr_ctrl)
			ctrl_reg <= bus.wdata & SRI_CTRL_WMASK;
		else if (mf_ev && mstr)
			ctrl_reg[CB_EN] <= 1'b0;
	end

	// Status configuration bits
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			{error_irq_enable_reg, mfen_reg, rate_reg} <= SRI_STAT_CFG_RST;
		else if (wr_stat)
		begin
			error_irq_enable_reg <= bus.wdata[SB_ERROR_IRQ_ENABLE];
			mfen_reg <= bus.wdata[SB_MFEN];
			rate_reg <= bus.wdata[SB_RATE_LO +: 2];
		end
	end

	// ==========================================
	// Flags, set wins over clear
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			arm_reg <= '0;
		else
		begin
			if (rd_stat)
				arm_reg <= {mode_fault_flag_reg, ovr_reg, rf_reg};
			else
			begin
				if (rd_data)
					arm_reg[1:0] <= 2'b00;
				if (wr_ctrl)
					arm_reg[2] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			rf_reg <= 1'b0;
		else if (done && !full)
			rf_reg <= 1'b1;
		else if (rx_clr)
			rf_reg <= 1'b0;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			ovr_reg <= 1'b0;
		else if (done && full)
			ovr_reg <= 1'b1;
		else if (rd_data && arm_reg[1])
			ovr_reg <= 1'b0;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			mode_fault_flag_reg <= 1'b0;
		else if (mf_ev)
			mode_fault_flag_reg <= 1'b1;
		else if (wr_ctrl && arm_reg[2])
			mode_fault_flag_reg <= 1'b0;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			te_reg <= 1'b1;
		else if (!en || load)
			te_reg <= 1'b1;
		else if (wr_data)
			te_reg <= 1'b0;
	end

	// ==========================================
	// Data registers
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			txd_reg <= SRI_ZERO8;
		else if (wr_data)
			txd_reg <= bus.wdata;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			rxd_reg <= SRI_ZERO8;
		else if (done && !full)
			rxd_reg <= rx_word;
	end

	// ==========================================
	// Shift engine
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			xfer_reg <= 1'b0;
			held_reg <= 1'b0;
			edge_reg <= '0;
			shreg_reg <= SRI_ZERO8;
			cap_reg <= 1'b0;
			out_bit_reg <= 1'b0;
		end
		else if (!en || ss_abort || (!mstr && i_ss_n && !clock_phase))
		begin
			xfer_reg <= 1'b0;
			edge_reg <= '0;
			cap_reg <= 1'b0;
			if (!en)
			begin
				held_reg <= 1'b0;
				shreg_reg <= SRI_ZERO8;
			end
		end
		else if (load)
		begin
			shreg_reg <= txd_reg;
			out_bit_reg <= txd_reg[7];
			held_reg <= !mstr;
			xfer_reg <= mstr;
		end
		else if (edge_ev)
		begin
			xfer_reg <= !last;
			edge_reg <= last ? '0 : edge_reg + 5'h01;
			if (last)
				held_reg <= 1'b0;
			if (samp)
				cap_reg <= sdi;
			else
			begin
				shreg_reg <= {shreg_reg[6:0], cap_reg};
				out_bit_reg <= clock_phase ? shreg_reg[7] : shreg_reg[6];
			end
			if (last)
				shreg_reg <= rx_word;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sclk_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
		end
		else
		begin
			sclk_d_reg <= i_sclk;
			if (!xfer_reg || !mstr)
				sclk_reg <= ctrl_reg[CB_CLOCK_POLARITY];
			else if (tick)
				sclk_reg <= !sclk_reg;
		end
	end

	// ==========================================
	// Register reads and interrupt request
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			bus.rdata <= SRI_ZERO8;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				SRI_CTRL_OFS: bus.rdata <= ctrl_reg;
				SRI_STAT_OFS: bus.rdata <= {rf_reg, error_irq_enable_reg, ovr_reg, mode_fault_flag_reg,
					te_reg, mfen_reg, rate_reg};
				SRI_DATA_OFS: bus.rdata <= rxd_reg;
				default: bus.rdata <= SRI_ZERO8;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
			bus.irq <= 1'b0;
		else
			bus.irq <= (ctrl_reg[CB_RIE] && rf_reg)
				|| (ctrl_reg[CB_TIE] && te_reg)
				|| (error_irq_enable_reg && (ovr_reg || mode_fault_flag_reg));
	end

	// ==========================================
	// Pin drivers
	function automatic logic oe_n(input logic drive, input logic od, input logic lvl);
		oe_n = !(drive && (!od || !lvl));
	endfunction

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			{o_sclk, o_mosi, o_miso} <= 3'b000;
			{o_sclk_oe_n, o_mosi_oe_n, o_miso_oe_n} <= 3'b111;
			o_ss_gpio <= 1'b1;
			o_pins_gpio <= 1'b1;
		end
		else
		begin
			o_sclk <= sclk_reg;
			o_mosi <= out_bit_reg;
			o_miso <= out_bit_reg;
			o_sclk_oe_n <= oe_n(en && mstr, wom, sclk_reg);
			o_mosi_oe_n <= oe_n(en && mstr, wom, out_bit_reg);
			o_miso_oe_n <= oe_n(sel, wom, out_bit_reg);
			o_ss_gpio <= !en || (mstr && !mfen_reg);
			o_pins_gpio <= !en;
		end
	end
endmodule

/* File: core/sri_controller.sv */
`timescale 1ns/1ps
module sri_controller
	import sri_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// AXI4-Lite write address
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [SRI_AXI_AW-1:0] i_awaddr,
	// AXI4-Lite write data
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// AXI4-Lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [SRI_AXI_AW-1:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// Device register port
	sri_bus_if.ctl bus
);
	sri_ctl_state_t state_reg;
	logic [SRI_AXI_AW-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic chk_reg, refused_reg;
	logic [7:0] result_reg;
	logic go, busy;

	assign busy = state_reg != CS_IDLE;
	assign go = !o_awready && !o_wready && !o_bvalid && awaddr_reg == CTL_CMD_OFS
		&& !busy && (&i_wstrb[2:0] || 1'b1);

	// ==========================================
	// Write channels
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= AXI_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= '0;
		end
		else
		begin
			if (o_awready && i_awvalid)
			begin
				o_awready <= 1'b0;
				awaddr_reg <= i_awaddr;
			end
			if (o_wready && i_wvalid)
			begin
				o_wready <= 1'b0;
				wdata_reg <= i_wdata;
			end
			if (!o_awready && !o_wready && !o_bvalid)
			begin
				o_bvalid <= 1'b1;
				o_bresp <= go ? AXI_OKAY : AXI_SLVERR;
			end
			if (o_bvalid && i_bready)
			begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// ==========================================
	// Read channel
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= AXI_OKAY;
		end
		else if (o_arready && i_arvalid)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= (i_araddr == CTL_STAT_OFS) ? AXI_OKAY : AXI_SLVERR;
			o_rdata <= (i_araddr == CTL_STAT_OFS)
				? {21'h0, bus.irq, refused_reg, busy, result_reg} : '0;
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ==========================================
	// Device access sequencer
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_reg <= CS_IDLE;
			bus.addr <= SRI_ZERO8;
			bus.wdata <= SRI_ZERO8;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			chk_reg <= 1'b0;
			refused_reg <= 1'b0;
			result_reg <= SRI_ZERO8;
		end
		else
		begin
			unique case (state_reg)
				CS_IDLE:
					if (go)
					begin
						// Plain write or plain read only, never a merged update
						bus.wdata <= wdata_reg[7:0];
						refused_reg <= 1'b0;
						state_reg <= CS_PULSE;
						if (wdata_reg[CMD_READ_BIT])
						begin
							bus.addr <= wdata_reg[15:8];
							bus.rd <= 1'b1;
						end
						else if (wdata_reg[15:8] == SRI_DATA_OFS)
						begin
							bus.addr <= SRI_STAT_OFS;
							bus.rd <= 1'b1;
							chk_reg <= 1'b1;
						end
						else
						begin
							bus.addr <= wdata_reg[15:8];
							bus.wr <= 1'b1;
						end
					end
				CS_PULSE:
				begin
					bus.wr <= 1'b0;
					bus.rd <= 1'b0;
					state_reg <= bus.rd ? CS_TAKE : CS_IDLE;
				end
				CS_TAKE:
					if (chk_reg)
					begin
						chk_reg <= 1'b0;
						if (bus.rdata[ST_TE_BIT])
						begin
							bus.addr <= SRI_DATA_OFS;
							bus.wr <= 1'b1;
							state_reg <= CS_PULSE;
						end
						else
						begin
							refused_reg <= 1'b1;
							state_reg <= CS_IDLE;
						end
					end
					else
					begin
						result_reg <= bus.rdata;
						state_reg <= CS_IDLE;
					end
				default: state_reg <= CS_IDLE;
			endcase
		end
	end
endmodule

/* File: dv/sri_properties.sv */
`timescale 1ns/1ps
module sri_properties
	import sri_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Device register port
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	// ==========================================
	// Shadow of what software last wrote
	logic dis_reg;
	logic error_irq_enable_reg;
	logic [7:0] ctl_reg;
	logic en_any;
	assign en_any = ctl_reg[CB_RIE] | ctl_reg[CB_TIE] | error_irq_enable_reg;
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctl_reg <= SRI_CTRL_RST;
			dis_reg <= 1'b1;
			error_irq_enable_reg <= 1'b0;
		end
		else if (wr && addr == SRI_CTRL_OFS)
		begin
			ctl_reg <= wdata & SRI_CTRL_WMASK;
			dis_reg <= !wdata[CB_EN];
		end
		else if (wr && addr == SRI_STAT_OFS)
			error_irq_enable_reg <= wdata[SB_ERROR_IRQ_ENABLE];
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	strobe_excl_a: assert property (!(wr && rd)) else $error("read and write together");
	wr_pulse_a: assert property (wr |=> !wr) else $error("long write strobe");
	rd_pulse_a: assert property (rd |=> !rd) else $error("long read strobe");
	rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata)) else $error("rdata moved");
	route_zero_a: assert property (rd && addr == SRI_CTRL_OFS |=> !rdata[6])
		else $error("route bit not zero");
	ctrl_shadow_a: assert property (rd && addr == SRI_CTRL_OFS |=>
		(rdata & 8'hbd) == (ctl_reg & 8'hbd)) else $error("control readback wrong");
	te_disabled_a: assert property (rd && addr == SRI_STAT_OFS && dis_reg |=> rdata[3])
		else $error("transmit empty low while disabled");
	wr_after_check_a: assert property (wr && addr == SRI_DATA_OFS |->
		$past(rd, 2) && $past(addr, 2) == SRI_STAT_OFS) else $error("data write unchecked");
	irq_quiet_a: assert property (!en_any && !$past(en_any) && !$past(en_any, 2) |-> !irq)
		else $error("irq with all enables off");
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
	import sri_pkg::*;
	logic clk, rst, awv, wv, bre, arv, rre, ss_n, wom_mode, last_sclk;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat;
	logic awr, wrd, bv, arr, rv, sclk_o, sclk_oen, mosi_o, mosi_oen, pins_gpio, ss_gpio, miso_oen;
	logic [1:0] br, rr;
	int err_count, check_count, cyc, cnt, half;
	wire sclk_w = sclk_oen ? 1'b1 : sclk_o;
	wire mosi_w = mosi_oen ? 1'b1 : mosi_o;
	sri_bus_if u_sri_bus_if();
	sri_controller u_sri_controller (.i_sys_clk(clk), .i_rst(rst), .i_awvalid(awv),
		.o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
		.i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bre), .o_bresp(br), .i_arvalid(arv),
		.o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(rre), .o_rdata(rdat),
		.o_rresp(rr), .bus(u_sri_bus_if));
	sri_device u_sri_device (.i_sys_clk(clk), .i_rst(rst), .bus(u_sri_bus_if), .i_sclk(sclk_w),
		.o_sclk(sclk_o), .o_sclk_oe_n(sclk_oen), .i_mosi(mosi_w), .o_mosi(mosi_o),
		.o_mosi_oe_n(mosi_oen), .i_miso(mosi_w), .o_miso(), .o_miso_oe_n(miso_oen), .i_ss_n(ss_n),
		.o_ss_gpio(ss_gpio), .o_pins_gpio(pins_gpio));
	sri_properties u_sri_properties (.i_sys_clk(clk), .i_rst(rst), .addr(u_sri_bus_if.addr),
		.wr(u_sri_bus_if.wr), .rd(u_sri_bus_if.rd), .wdata(u_sri_bus_if.wdata),
		.rdata(u_sri_bus_if.rdata), .irq(u_sri_bus_if.irq));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================
	// Reporting
	task automatic fail(input string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) fail(m);
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Clock half-period meter, open-drain watch and timeout
	always @(posedge clk)
	begin
		cyc++;
		if (sclk_o !== last_sclk)
		begin
			half = cnt;
			cnt = 1;
		end
		else
			cnt++;
		last_sclk = sclk_o;
		if (wom_mode && !sclk_oen && sclk_o) fail("open-drain pin driven high");
		if (cyc == 60000)
		begin
			fail("timeout");
			complete_run();
		end
	end
	// ==========================================
	// AXI4-Lite master and command helpers
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		bre <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end
		while (!bv);
		bre <= 1'b0;
		r = br;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end
		while (!rv);
		rre <= 1'b0;
		d = rdat;
		r = rr;
	endtask
	task automatic dev_cmd(input logic [31:0] c, output logic [7:0] v);
		logic [1:0] r;
		logic [31:0] s;
		axi_wr(CTL_CMD_OFS, c, r);
		chk(r, AXI_OKAY, "command refused");
		repeat (6) @(posedge clk);
		do axi_rd(CTL_STAT_OFS, s, r); while (s[8]);
		v = s[7:0];
	endtask
	task automatic dev_wr(input logic [7:0] o, input logic [7:0] d);
		logic [7:0] v;
		dev_cmd({15'h0000, 1'b0, o, d}, v);
	endtask
	task automatic dev_rd(input logic [7:0] o, output logic [7:0] v);
		dev_cmd({15'h0000, 1'b1, o, 8'h00}, v);
	endtask
	task automatic wait_flag(input int b, output logic [7:0] v);
		do dev_rd(SRI_STAT_OFS, v); while (!v[b]);
	endtask
	task automatic irq_chk(input logic e);
		logic [31:0] s;
		logic [1:0] r;
		axi_rd(CTL_STAT_OFS, s, r);
		chk(s[10], e, "irq level");
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] v;
		logic [31:0] s;
		logic [1:0] r;
		dev_rd(SRI_CTRL_OFS, v);
		chk(v, SRI_CTRL_RST, "control reset value");
		dev_rd(SRI_STAT_OFS, v);
		chk(v, 8'h08, "status reset value");
		chk(pins_gpio, 1'b1, "pins held while disabled");
		axi_wr(8'h08, 32'h0, r);
		chk(r, AXI_SLVERR, "unmapped write");
		axi_rd(8'h00, s, r);
		chk(r, AXI_SLVERR, "unmapped read");
		dev_wr(SRI_CTRL_OFS, 8'hff);
		dev_rd(SRI_CTRL_OFS, v);
		chk(v, 8'hbf, "control readback");
		irq_chk(1'b1);
		dev_wr(SRI_CTRL_OFS, 8'h28);
		irq_chk(1'b0);
	endtask
	task automatic t_rates();
		logic [7:0] v;
		logic [7:0] d;
		for (int r = 0; r < 4; r++)
		begin
			d = 8'h5a ^ 8'(r);
			wom_mode <= 1'b0;
			dev_wr(SRI_STAT_OFS, {6'h00, r[1:0]});
			dev_wr(SRI_CTRL_OFS, {r[0], 2'b01, r[0], !r[0], r[1], 2'b10});
			wom_mode <= r[1];
			chk(sclk_w, r[0], "idle clock level");
			chk(pins_gpio, 1'b0, "pins not claimed while enabled");
			dev_wr(SRI_DATA_OFS, d);
			wait_flag(7, v);
			chk(half, SRI_BD[r], "clock half period");
			chk(v[3], 1'b1, "transmit not empty");
			irq_chk(r[0]);
			dev_rd(SRI_DATA_OFS, v);
			chk(v, d, "received byte");
			dev_rd(SRI_STAT_OFS, v);
			chk(v[7], 1'b0, "receive flag stuck");
		end
		wom_mode <= 1'b0;
	endtask
	task automatic t_overflow();
		logic [7:0] v;
		dev_wr(SRI_DATA_OFS, 8'h3c);
		wait_flag(7, v);
		dev_wr(SRI_DATA_OFS, 8'hc3);
		wait_flag(5, v);
		dev_rd(SRI_DATA_OFS, v);
		chk(v, 8'h3c, "old byte lost");
		dev_rd(SRI_STAT_OFS, v);
		chk(v[7:5], 3'h0, "flags not cleared");
	endtask
	task automatic t_fault();
		logic [7:0] v;
		dev_wr(SRI_STAT_OFS, 8'h44);
		chk(ss_gpio, 1'b0, "select pin not claimed by master");
		ss_n <= 1'b0;
		dev_rd(SRI_STAT_OFS, v);
		ss_n <= 1'b1;
		chk(v[4], 1'b1, "no mode fault");
		chk(pins_gpio, 1'b1, "fault left module enabled");
		irq_chk(1'b1);
		dev_wr(SRI_STAT_OFS, 8'h40);
		dev_rd(SRI_STAT_OFS, v);
		chk(v[4], 1'b1, "fault lost with detect off");
		dev_wr(SRI_CTRL_OFS, 8'h28);
		dev_rd(SRI_STAT_OFS, v);
		chk(v[4], 1'b0, "fault not cleared");
		irq_chk(1'b0);
		chk(ss_gpio, 1'b1, "select pin held while disabled");
		dev_wr(SRI_CTRL_OFS, 8'h0a);
		ss_n <= 1'b0;
		dev_rd(SRI_STAT_OFS, v);
		chk(ss_gpio, 1'b0, "select pin free as slave");
		chk(miso_oen, 1'b0, "selected slave not driving");
		ss_n <= 1'b1;
		dev_rd(SRI_STAT_OFS, v);
		chk(miso_oen, 1'b1, "deselected slave driving");
		dev_wr(SRI_CTRL_OFS, 8'h28);
	endtask
	initial
	begin
		rst = 1'b1;
		{awv, wv, bre, arv, rre, wom_mode, last_sclk} = '0;
		{awa, ara, wd} = '0;
		ss_n = 1'b1;
		{err_count, check_count, cyc, cnt, half} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rates();
		t_overflow();
		t_fault();
		complete_run();
	end
endmodule
